// ### design/ppf_delay.sv
// enable-gated delay line of fixed depth
`timescale 1ns/10ps
`default_nettype none
module ppf_delay #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 3
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // stream
    input  wire logic             en,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage_ff [DEPTH];

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_stage
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    stage_ff[i] <= '0;
                end else if (en) begin
                    stage_ff[i] <= (i == 0) ? d : stage_ff[(i == 0) ? 0 : i-1];
                end
            end
        end
    endgenerate

    assign q = stage_ff[DEPTH-1];
endmodule
`default_nettype wire

// ### design/ppf_format_mux.sv
// pixel port formatting: endian, vga pass-through, pseudo/direct unpack
`timescale 1ns/10ps
`default_nettype none
`include "ppf_params.svh"
module ppf_format_mux #(
    parameter int BUS_W   = `PPF_BUS_WIDTH,
    parameter int DOT_DIV = `PPF_DOT_DIV
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_b,
    // configuration load
    input  wire logic                cfgLoad,
    input  wire ppf_pkg::ppf_cfg_s   cfgIn,
    input  wire logic [7:0]          palettePage,
    input  wire logic [7:0]          readMask,
    output ppf_pkg::ppf_cfg_s        cfgState,
    // pixel port pins
    input  wire logic                pixelLatchClock,
    input  wire logic [BUS_W-1:0]    pixelBus,
    input  wire logic                sysBlankIn,
    // vga port pins
    input  wire logic                vgaDotClock,
    input  wire logic [7:0]          vgaPixelIn,
    input  wire logic                vgaBlankIn,
    input  wire logic                vgaHsyncIn,
    input  wire logic                vgaVsyncIn,
    // palette ram
    output logic [7:0]               palAddr,
    output logic                     palRead,
    input  wire logic [23:0]         palData,
    // toward the dacs
    output ppf_pkg::ppf_rgb_s        dacRgb,
    output ppf_pkg::ppf_rgb_s        overlayRgb,
    output logic                     overlayValid,
    output ppf_pkg::ppf_ctl_s        dacCtl,
    output logic                     pixValid
);
    localparam int SW = BUS_W + 8 + 3 + 3;
    localparam int DW = (DOT_DIV > 1) ? $clog2(DOT_DIV) : 1;

    ppf_pkg::ppf_cfg_s   cfg_ff;
    ppf_pkg::ppf_state_e state_ff;
    logic [SW-1:0]       pinSync;
    logic [BUS_W-1:0]    busSync;
    logic [7:0]          vgaPixSync;
    ppf_pkg::ppf_ctl_s   vgaCtlSync;
    logic                sysBlankSync, latchSync, vgaClkSync;
    logic                latchPrev_ff, vgaClkPrev_ff;
    logic                latchTick, vgaTick, intTick, emit;
    logic [DW-1:0]       dotCnt_ff;
    logic [BUS_W-1:0]    word_ff;
    logic                wordBlank_ff;
    logic [5:0]          chanIdx_ff, chanSel;
    logic [6:0]          ratio, bpp;
    logic [31:0]         pix;
    logic [10:0]         shiftAmt;
    logic [10:0]         vgaDlyOut;
    logic                isDirect, hasOvl;
    logic [7:0]          fmtAddr;
    ppf_pkg::ppf_rgb_s   fmtRgb;
    logic [7:0]          vgaSrcPix;
    ppf_pkg::ppf_ctl_s   vgaSrcCtl;
    logic [7:0]          palAddr_ff;
    ppf_pkg::ppf_rgb_s   direct1_ff;
    ppf_pkg::ppf_ctl_s   ctl1_ff;
    ppf_pkg::ppf_mode_e  mode1_ff;
    logic                valid1_ff, directSel1_ff, ovl1_ff, cfgSeen_ff;

    // configuration register with documented reset state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff.endianBig           <= `PPF_RST_ENDIAN;
            cfg_ff.vgaPortEnable       <= `PPF_RST_VGA_EN;
            cfg_ff.frameSelfClocked    <= `PPF_RST_SELF_CLK;
            cfg_ff.mode                <= ppf_pkg::MODE_PSEUDO8;
            cfg_ff.muxRatioLog2        <= `PPF_RST_RATIO;
            cfg_ff.auxWindowEnable     <= `PPF_RST_AUX_WIN;
            cfg_ff.portSelectEnable    <= `PPF_RST_PORT_SEL;
            cfg_ff.windowPaletteSelect <= `PPF_RST_WIN_PAL;
            cfg_ff.keyPaletteSelect    <= `PPF_RST_KEY_PAL;
            cfg_ff.keyCompareEnable    <= `PPF_RST_KEY_CMP;
        end else if (cfgLoad) begin
            cfg_ff <= cfgIn;
        end
    end
    assign cfgState = cfg_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgSeen_ff <= 1'b0;
        end else if (cfgLoad) begin
            cfgSeen_ff <= 1'b1;
        end
    end

    // every pin passes two flops before use
    ppf_sync #(.WIDTH(SW)) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     ({pixelBus, vgaPixelIn, vgaBlankIn, vgaHsyncIn, vgaVsyncIn,
                 sysBlankIn, pixelLatchClock, vgaDotClock}),
        .q     (pinSync)
    );
    assign {busSync, vgaPixSync, vgaCtlSync, sysBlankSync, latchSync,
            vgaClkSync} = pinSync;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            latchPrev_ff  <= 1'b0;
            vgaClkPrev_ff <= 1'b0;
        end else begin
            latchPrev_ff  <= latchSync;
            vgaClkPrev_ff <= vgaClkSync;
        end
    end
    assign latchTick = latchSync & ~latchPrev_ff;
    assign vgaTick   = vgaClkSync & ~vgaClkPrev_ff;

    // internal dot rate divider for unpacking multiplexed words
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dotCnt_ff <= '0;
        end else if (dotCnt_ff == DW'(DOT_DIV - 1)) begin
            dotCnt_ff <= '0;
        end else begin
            dotCnt_ff <= dotCnt_ff + DW'(1);
        end
    end
    assign intTick = (dotCnt_ff == '0);

    // vga port enabled: pixel port unpacking is held off entirely
    assign emit = intTick && (state_ff == ppf_pkg::ST_UNPACK)
                  && !cfg_ff.vgaPortEnable;

    // word capture and channel walk; a new latch edge restarts the walk
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff     <= ppf_pkg::ST_IDLE;
            word_ff      <= '0;
            wordBlank_ff <= 1'b0;
            chanIdx_ff   <= 6'h00;
        end else if (cfg_ff.vgaPortEnable) begin
            state_ff   <= ppf_pkg::ST_IDLE;
            chanIdx_ff <= 6'h00;
        end else begin
            case (state_ff)
                ppf_pkg::ST_IDLE: begin
                    if (latchTick) begin
                        word_ff      <= busSync;
                        wordBlank_ff <= sysBlankSync;
                        chanIdx_ff   <= 6'h00;
                        state_ff     <= ppf_pkg::ST_UNPACK;
                    end
                end
                ppf_pkg::ST_UNPACK: begin
                    if (latchTick) begin
                        word_ff      <= busSync;
                        wordBlank_ff <= sysBlankSync;
                        chanIdx_ff   <= 6'h00;
                    end else if (emit) begin
                        if ({1'b0, chanIdx_ff} == ratio - 7'h01) begin
                            state_ff <= ppf_pkg::ST_IDLE;
                        end
                        chanIdx_ff <= chanIdx_ff + 6'h01;
                    end
                end
                default: state_ff <= ppf_pkg::ST_IDLE;
            endcase
        end
    end

    // bits per pixel in each mode
    always_comb begin
        case (cfg_ff.mode)
            ppf_pkg::MODE_PSEUDO1:  bpp = 7'h01;
            ppf_pkg::MODE_PSEUDO2:  bpp = 7'h02;
            ppf_pkg::MODE_PSEUDO4:  bpp = 7'h04;
            ppf_pkg::MODE_PSEUDO8:  bpp = 7'h08;
            ppf_pkg::MODE_DIR_ORGB,
            ppf_pkg::MODE_DIR_BGRO: bpp = 7'h20;
            default:                bpp = 7'h10;
        endcase
    end

    // big-endian puts the first pixel in the top channel of the used width
    assign ratio    = 7'h01 << cfg_ff.muxRatioLog2;
    assign chanSel  = cfg_ff.endianBig
                      ? 6'(ratio - 7'h01 - {1'b0, chanIdx_ff})
                      : chanIdx_ff;
    assign shiftAmt = 11'(chanSel * bpp);
    assign pix      = 32'(word_ff >> shiftAmt);

    // field unpack: narrow colors left-justified, overlay in low addr bits
    always_comb begin
        isDirect = 1'b1;
        hasOvl   = 1'b0;
        fmtAddr  = palettePage;
        fmtRgb   = '0;
        case (cfg_ff.mode)
            ppf_pkg::MODE_PSEUDO1: begin
                isDirect = 1'b0;
                fmtAddr  = {palettePage[7:1], pix[0]};
            end
            ppf_pkg::MODE_PSEUDO2: begin
                isDirect = 1'b0;
                fmtAddr  = {palettePage[7:2], pix[1:0]};
            end
            ppf_pkg::MODE_PSEUDO4: begin
                isDirect = 1'b0;
                fmtAddr  = {palettePage[7:4], pix[3:0]};
            end
            ppf_pkg::MODE_PSEUDO8: begin
                isDirect = 1'b0;
                fmtAddr  = pix[7:0];
            end
            ppf_pkg::MODE_DIR_ORGB: begin
                hasOvl  = 1'b1;
                fmtAddr = pix[31:24];
                fmtRgb  = {pix[23:16], pix[15:8], pix[7:0]};
            end
            ppf_pkg::MODE_DIR_BGRO: begin
                hasOvl  = 1'b1;
                fmtAddr = pix[7:0];
                fmtRgb  = {pix[15:8], pix[23:16], pix[31:24]};
            end
            ppf_pkg::MODE_DIR_565: begin
                fmtRgb = {pix[15:11], 3'h0, pix[10:5], 2'h0,
                          pix[4:0], 3'h0};
            end
            ppf_pkg::MODE_DIR_555: begin
                hasOvl  = 1'b1;
                fmtAddr = {palettePage[7:1], pix[15]};
                fmtRgb  = {pix[14:10], 3'h0, pix[9:5], 3'h0,
                           pix[4:0], 3'h0};
            end
            ppf_pkg::MODE_DIR_664: begin
                fmtRgb = {pix[15:10], 2'h0, pix[9:4], 2'h0,
                          pix[3:0], 4'h0};
            end
            ppf_pkg::MODE_DIR_4444: begin
                hasOvl  = 1'b1;
                fmtAddr = {palettePage[7:4], pix[15:12]};
                fmtRgb  = {pix[11:8], 4'h0, pix[7:4], 4'h0,
                           pix[3:0], 4'h0};
            end
            default: isDirect = 1'b0;
        endcase
    end

    // self-clocked timing: three extra vga dot stages on data, blank and syncs
    ppf_delay #(.WIDTH(11), .DEPTH(`PPF_SELF_VGA_DELAY)) u_vga_dly (
        .clk   (clk),
        .rst_b (rst_b),
        .en    (vgaTick),
        .d     ({vgaPixSync, vgaCtlSync}),
        .q     (vgaDlyOut)
    );
    assign {vgaSrcPix, vgaSrcCtl} = cfg_ff.frameSelfClocked
        ? vgaDlyOut : {vgaPixSync, vgaCtlSync};

    // stage 1: palette address, direct color held one slot for the read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            valid1_ff     <= 1'b0;
            palAddr_ff    <= 8'h00;
            direct1_ff    <= '0;
            ctl1_ff       <= '0;
            directSel1_ff <= 1'b0;
            ovl1_ff       <= 1'b0;
            mode1_ff      <= ppf_pkg::MODE_PSEUDO8;
        end else if (cfg_ff.vgaPortEnable) begin
            // vga port follows only its own dot clock
            valid1_ff     <= vgaTick;
            directSel1_ff <= 1'b0;
            ovl1_ff       <= 1'b0;
            if (vgaTick) begin
                palAddr_ff <= vgaSrcPix & readMask;
                ctl1_ff    <= vgaSrcCtl;
            end
        end else begin
            valid1_ff     <= emit;
            directSel1_ff <= isDirect;
            ovl1_ff       <= isDirect & hasOvl;
            mode1_ff      <= cfg_ff.mode;
            if (emit) begin
                palAddr_ff <= fmtAddr & readMask;
                direct1_ff <= fmtRgb;
                ctl1_ff    <= '{blank: wordBlank_ff, hsync: vgaCtlSync.hsync,
                                vsync: vgaCtlSync.vsync};
            end
        end
    end
    assign palAddr = palAddr_ff;
    assign palRead = valid1_ff;

    // stage 2: palette answer and direct color leave together
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dacRgb       <= '0;
            overlayRgb   <= '0;
            overlayValid <= 1'b0;
            dacCtl       <= '0;
            pixValid     <= 1'b0;
        end else begin
            pixValid     <= valid1_ff;
            overlayValid <= valid1_ff & ovl1_ff;
            if (valid1_ff) begin
                dacRgb     <= directSel1_ff ? direct1_ff : palData;
                overlayRgb <= palData;
                dacCtl     <= ctl1_ff;
            end
        end
    end

    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_reset_passthru: assert property (
        !cfgSeen_ff |-> cfg_ff.vgaPortEnable && !cfg_ff.endianBig
                        && cfg_ff.windowPaletteSelect
                        && cfg_ff.keyPaletteSelect
                        && cfg_ff.keyCompareEnable == 4'h0
                        && !cfg_ff.auxWindowEnable)
        else $error("reset configuration not vga pass-through");
    a_vga_hold_idle: assert property (
        cfg_ff.vgaPortEnable ##1 cfg_ff.vgaPortEnable
        |-> state_ff == ppf_pkg::ST_IDLE)
        else $error("pixel unpack active while vga port enabled");
    a_vga_capture: assert property (
        cfg_ff.vgaPortEnable && !cfg_ff.frameSelfClocked && vgaTick
        |=> valid1_ff && palAddr_ff == ($past(vgaPixSync) & $past(readMask)))
        else $error("vga pixel not captured on dot edge");
    a_latch_no_vga: assert property (
        cfg_ff.vgaPortEnable && !vgaTick |=> !valid1_ff)
        else $error("vga stage fired without a vga dot edge");
    a_self_delay: assert property (
        cfg_ff.vgaPortEnable && cfg_ff.frameSelfClocked && vgaTick
        |=> palAddr_ff == ($past(vgaDlyOut[10:3]) & $past(readMask))
            && ctl1_ff == $past(vgaDlyOut[2:0]))
        else $error("self-clocked vga path not delayed");
    a_page_one_bit: assert property (
        emit && cfg_ff.mode == ppf_pkg::MODE_PSEUDO1 && !cfgLoad
        |=> palAddr_ff[7:1] == ($past(palettePage[7:1]) & $past(readMask[7:1])))
        else $error("1-bit pseudo-color page bits wrong");
    a_byte_no_page: assert property (
        emit && cfg_ff.mode == ppf_pkg::MODE_PSEUDO8
        |=> palAddr_ff == ($past(pix[7:0]) & $past(readMask)))
        else $error("8-bit pseudo-color address wrong");
    a_left_justify: assert property (
        valid1_ff && directSel1_ff && mode1_ff == ppf_pkg::MODE_DIR_4444
        |-> direct1_ff.red[3:0] == 4'h0 && direct1_ff.green[3:0] == 4'h0
            && direct1_ff.blue[3:0] == 4'h0)
        else $error("narrow color not zero filled");
    a_direct_timing: assert property (
        valid1_ff && directSel1_ff
        |=> pixValid && dacRgb == $past(direct1_ff) && dacCtl == $past(ctl1_ff))
        else $error("direct color delay differs from control");
    a_overlay_color: assert property (
        valid1_ff && ovl1_ff |=> overlayValid && overlayRgb == $past(palData))
        else $error("overlay color not taken from palette");
    a_first_channel: assert property (
        latchTick && !cfg_ff.vgaPortEnable && !cfgLoad |=> chanIdx_ff == 6'h00)
        else $error("unpack did not start at first channel");
endmodule
`default_nettype wire

// ### design/ppf_params.svh
// constants for the pixel port format mux
// Notes on behaviour
// - bus is little-endian while endian bit 3 is 0 (reset), big-endian when 1.
// - after reset the block runs in vga pass-through mode.
// - with vga port enabled the vga dot clock is the input clock.
// - vga data, blank and syncs are captured on vga dot clock edges; pixel port mode samples the syncs at each emitted pixel.
// - pixel latch clock captures only the pixel bus and system blank, never the vga port.
// - self-clocked timing adds dot-clock pipeline stages to the vga path.
// - that added vga delay is three dot stages, on data, blank and syncs.
// - pseudo-color pixel addresses the palette, which returns 24 bits.
// - 1-bit pseudo-color: pixel at address bit 0, page gives upper 7.
// - 2-bit pseudo-color: pixel in low 2 bits, page gives upper 6.
// - 4-bit pseudo-color: pixel in low 4 bits, page gives upper 4.
// - 8-bit pseudo-color: all address bits from pixel, page ignored.
// - direct color bypasses palette with the same delay as overlay.
// - leftover overlay bits address the palette as overlay color.
// - reset: window, port select, key compares 0; vga and selects 1.
// - 24-bit direct: 8 per color plus overlay, orgb or bgro order.
// - 5-6-5 direct color, no overlay.
// - 5-5-5 direct color plus one overlay bit.
// - 6-6-4 direct color, no overlay.
// - 4-4-4-4 direct color with four overlay bits.
// - narrow color fields left-justified with zero-filled low bits.
// - narrow overlay in low address bits, page fills upper, mask applies.
`ifndef PPF_PARAMS_SVH
`define PPF_PARAMS_SVH
`define PPF_BUS_WIDTH      64
`define PPF_VGA_WIDTH      8
`define PPF_SYNC_STAGES    2
`define PPF_SELF_VGA_DELAY 3
`define PPF_DOT_DIV        1
`define PPF_RST_ENDIAN     1'b0
`define PPF_RST_VGA_EN     1'b1
`define PPF_RST_SELF_CLK   1'b0
`define PPF_RST_RATIO      3'h0
`define PPF_RST_AUX_WIN    1'b0
`define PPF_RST_PORT_SEL   1'b0
`define PPF_RST_WIN_PAL    1'b1
`define PPF_RST_KEY_PAL    1'b1
`define PPF_RST_KEY_CMP    4'h0
`endif

// ### design/ppf_pkg.sv
// types shared by the pixel port format mux
package ppf_pkg;
    typedef enum logic [3:0] {
        MODE_PSEUDO1  = 4'h0,
        MODE_PSEUDO2  = 4'h1,
        MODE_PSEUDO4  = 4'h2,
        MODE_PSEUDO8  = 4'h3,
        MODE_DIR_ORGB = 4'h4,
        MODE_DIR_BGRO = 4'h5,
        MODE_DIR_565  = 4'h6,
        MODE_DIR_555  = 4'h7,
        MODE_DIR_664  = 4'h8,
        MODE_DIR_4444 = 4'h9
    } ppf_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_UNPACK = 2'h1
    } ppf_state_e;

    typedef struct packed {
        logic       endianBig;
        logic       vgaPortEnable;
        logic       frameSelfClocked;
        ppf_mode_e  mode;
        logic [2:0] muxRatioLog2;
        logic       auxWindowEnable;
        logic       portSelectEnable;
        logic       windowPaletteSelect;
        logic       keyPaletteSelect;
        logic [3:0] keyCompareEnable;
    } ppf_cfg_s;

    typedef struct packed {
        logic blank;
        logic hsync;
        logic vsync;
    } ppf_ctl_s;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } ppf_rgb_s;
endpackage

// ### design/ppf_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module ppf_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;

    // meta_ff feeds only the second flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// ### test/ppf_pixel_source.sv
// model of the frame buffer and vga feature connector driving the pins
`timescale 1ns/10ps
`default_nettype none
module ppf_pixel_source (
    // pixel port
    output logic        pixelLatchClock,
    output logic [63:0] pixelBus,
    output logic        sysBlankIn,
    // vga port
    output logic        vgaDotClock,
    output logic [7:0]  vgaPixelIn,
    output logic        vgaBlankIn,
    output logic        vgaHsyncIn,
    output logic        vgaVsyncIn
);
    // link clocks stand still between words, so edges come only from tasks
    initial begin
        pixelLatchClock = 1'b0;
        pixelBus = '0;
        sysBlankIn = 1'b0;
        vgaDotClock = 1'b0;
        vgaPixelIn = '0;
        vgaBlankIn = 1'b0;
        vgaHsyncIn = 1'b0;
        vgaVsyncIn = 1'b0;
    end
    // odd offset keeps pin edges off the sampling clock edge
    // after the hold, data and blank lines show the inverse so stale data cannot pass; vga syncs keep their value
    task automatic sendWord(input logic [63:0] w, input logic bl);
        #23 pixelBus = w;
        sysBlankIn = bl;
        #400 pixelLatchClock = 1'b1;
        #400 pixelLatchClock = 1'b0;
        pixelBus = ~w;
        sysBlankIn = ~bl;
    endtask
    task automatic sendVga(input logic [7:0] p, input logic [2:0] ctl);
        #23 vgaPixelIn = p;
        {vgaBlankIn, vgaHsyncIn, vgaVsyncIn} = ctl;
        #400 vgaDotClock = 1'b1;
        #400 vgaDotClock = 1'b0;
        vgaPixelIn = ~p;
        vgaBlankIn = ~ctl[2];
    endtask
endmodule
`default_nettype wire

// ### test/test_ppf_format_mux.sv
// self-checking bench for the pixel port format mux
`timescale 1ns/10ps
`default_nettype none
module test_ppf_format_mux;
    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    logic              cfgLoad = 1'b0;
    ppf_pkg::ppf_cfg_s cfgIn = '0;
    ppf_pkg::ppf_cfg_s cfgState;
    ppf_pkg::ppf_cfg_s rstCfg;
    logic [7:0]        palettePage = 8'hB6;
    logic [7:0]        readMask = 8'hFF;
    logic              latchClk, sysBlank, dotClk, vBlank, vHs, vVs;
    logic [63:0]       pixelBus;
    logic [7:0]        vPix, palAddr;
    logic              palRead, overlayValid, pixValid;
    logic [23:0]       palData;
    ppf_pkg::ppf_rgb_s dacRgb, overlayRgb;
    ppf_pkg::ppf_ctl_s dacCtl;
    logic [52:0]       seen[$];
    logic              readPrev = 1'b0;
    int                fails = 0;
    int                n_compared = 0;
    localparam logic [63:0] WORD = 64'h8F3CA5176BD24E09;

    always #50 clk = ~clk;

    function automatic logic [23:0] pal(input logic [7:0] a);
        return {a, ~a, a ^ 8'hA5};
    endfunction
    // palette answers in the same cycle as the address
    assign palData = pal(palAddr);

    ppf_pixel_source partnerU (.pixelLatchClock(latchClk), .pixelBus(pixelBus),
        .sysBlankIn(sysBlank), .vgaDotClock(dotClk), .vgaPixelIn(vPix),
        .vgaBlankIn(vBlank), .vgaHsyncIn(vHs), .vgaVsyncIn(vVs));

    ppf_format_mux dut_u (.clk(clk), .rst_b(rst_b), .cfgLoad(cfgLoad),
        .cfgIn(cfgIn), .palettePage(palettePage), .readMask(readMask),
        .cfgState(cfgState), .pixelLatchClock(latchClk), .pixelBus(pixelBus),
        .sysBlankIn(sysBlank), .vgaDotClock(dotClk), .vgaPixelIn(vPix),
        .vgaBlankIn(vBlank), .vgaHsyncIn(vHs), .vgaVsyncIn(vVs),
        .palAddr(palAddr), .palRead(palRead), .palData(palData),
        .dacRgb(dacRgb), .overlayRgb(overlayRgb),
        .overlayValid(overlayValid), .dacCtl(dacCtl), .pixValid(pixValid));

    // every output pixel: {read one cycle before, ctl, overlay valid,
    // overlay rgb, dac rgb}; the palette read must lead each pixel
    always @(posedge clk) begin
        readPrev <= palRead;
        if (pixValid === 1'b1) begin
            seen.push_back({readPrev, dacCtl, overlayValid, overlayRgb,
                            dacRgb});
        end
    end

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", what, e, g);
            fails++;
        end
    endtask

    task automatic waitPix(input int n);
        for (int i = 0; i < 80 && seen.size() < n; i++) @(posedge clk);
        if (seen.size() < n) begin
            fails++;
            finish_test();
        end
        repeat (6) @(posedge clk);
        chk("pixel count", n, seen.size());
        foreach (seen[i]) chk("palRead", 1'b1, seen[i][52]);
    endtask

    task automatic setCfg(input ppf_pkg::ppf_cfg_s c);
        @(posedge clk);
        cfgLoad <= 1'b1;
        cfgIn <= c;
        @(posedge clk);
        cfgLoad <= 1'b0;
        @(posedge clk);
        chk("cfgState", c, cfgState);
        seen.delete();
    endtask

    // latch edges during pass-through must not produce pixels
    task automatic vgaPass();
        readMask <= 8'h7F;
        fork
            partnerU.sendVga(8'hC5, 3'b101);
            partnerU.sendWord(WORD, 1'b0);
        join
        partnerU.sendVga(8'h3A, 3'b010);
        waitPix(2);
        chk("vga dac", pal(8'h45), seen[0][23:0]);
        chk("vga ctl", 3'b101, seen[0][51:49]);
        chk("vga dac", pal(8'h3A), seen[1][23:0]);
        chk("vga ctl", 3'b010, seen[1][51:49]);
        $display("test vgaPass done");
    endtask

    task automatic vgaSelfClocked();
        ppf_pkg::ppf_cfg_s c;
        c = rstCfg;
        c.frameSelfClocked = 1'b1;
        setCfg(c);
        for (int k = 0; k < 5; k++) begin
            partnerU.sendVga(8'h21 + 8'(k), {k[0], 2'b00});
        end
        waitPix(5);
        chk("delayed dac", pal(8'h21), seen[3][23:0]);
        chk("delayed blank", 1'b0, seen[3][51]);
        chk("delayed dac", pal(8'h22), seen[4][23:0]);
        chk("delayed blank", 1'b1, seen[4][51]);
        $display("test vgaSelfClocked done");
    endtask

    // every mode, both endians, ratio 8 for pseudo-color, widest ratio that fits the bus for direct color
    task automatic pixModes();
        ppf_pkg::ppf_cfg_s c;
        logic [31:0] ch;
        logic [23:0] col;
        logic [7:0] a;
        logic ov;
        int lg, bpp, chan;
        readMask <= 8'hFF;
        for (int m = 0; m < 10; m++) begin
            for (int big = 0; big < 2; big++) begin
                lg = m < 4 ? 3 : (m < 6 ? 1 : 2);
                bpp = m < 4 ? (1 << m) : (m < 6 ? 32 : 16);
                c = rstCfg;
                c.vgaPortEnable = 1'b0;
                c.frameSelfClocked = 1'b1;
                c.endianBig = big[0];
                c.mode = ppf_pkg::ppf_mode_e'(m[3:0]);
                c.muxRatioLog2 = lg[2:0];
                setCfg(c);
                partnerU.sendWord(WORD, big[0]);
                waitPix(1 << lg);
                for (int i = 0; i < (1 << lg); i++) begin
                    chan = big ? (1 << lg) - 1 - i : i;
                    ch = 32'((WORD >> (chan * bpp)) & ((64'h1 << bpp) - 1));
                    ov = (m == 4 || m == 5 || m == 7 || m == 9);
                    a = palettePage;
                    case (m)
                        0: a = {palettePage[7:1], ch[0]};
                        1: a = {palettePage[7:2], ch[1:0]};
                        2: a = {palettePage[7:4], ch[3:0]};
                        3: a = ch[7:0];
                        4: {a, col} = ch;
                        5: {col[7:0], col[15:8], col[23:16], a} = ch;
                        6: col = {ch[15:11], 3'h0, ch[10:5], 2'h0,
                                  ch[4:0], 3'h0};
                        7: {a[0], col} = {ch[15], ch[14:10], 3'h0,
                               ch[9:5], 3'h0, ch[4:0], 3'h0};
                        8: col = {ch[15:10], 2'h0, ch[9:4], 2'h0,
                                  ch[3:0], 4'h0};
                        default: {a[3:0], col} = {ch[15:12], ch[11:8], 4'h0,
                               ch[7:4], 4'h0, ch[3:0], 4'h0};
                    endcase
                    if (m < 4) col = pal(a & readMask);
                    chk("dacRgb", col, seen[i][23:0]);
                    if (ov) chk("overlayRgb", pal(a & readMask),
                                seen[i][47:24]);
                    chk("overlayValid", ov, seen[i][48]);
                    chk("pixel blank", big[0], seen[i][51]);
                end
            end
        end
        $display("test pixModes done");
    endtask

    initial begin
        rstCfg = '0;
        rstCfg.vgaPortEnable = 1'b1;
        rstCfg.windowPaletteSelect = 1'b1;
        rstCfg.keyPaletteSelect = 1'b1;
        rstCfg.mode = ppf_pkg::MODE_PSEUDO8;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("reset cfgState", rstCfg, cfgState);
        chk("reset pixValid", 1'b0, pixValid);
        $display("test reset done");
        vgaPass();
        vgaSelfClocked();
        pixModes();
        finish_test();
    end
endmodule
`default_nettype wire
